// [pmsw_pkg.sv]
package pmsw_pkg;
   // Clock rate and oscillator settle times
   localparam int CLK_PERIOD_NS   = 100;
   localparam int HS_SETTLE_NS    = 16000;
   localparam int LS_SETTLE_NS    = 100000;
   localparam int HS_SETTLE_CYC   = (HS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LS_SETTLE_CYC   = (LS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] OFS_CLK_CTRL  = 8'h00;
   localparam logic [7:0] OFS_HS_CTRL   = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h08;
   localparam logic [7:0] OFS_WAKE_EN   = 8'h0C;
   localparam logic [7:0] OFS_WDT_CTRL  = 8'h10;

   // Field positions
   localparam int SEL_LSB         = 5;
   localparam int FAST_KEEP_BIT   = 1;
   localparam int SLOW_KEEP_BIT   = 0;
   localparam int HS_EN_BIT       = 0;
   localparam int HS_STABLE_BIT   = 1;
   localparam int HS_FREQ_LSB     = 2;
   localparam int ST_PDF_BIT      = 0;
   localparam int ST_TO_BIT       = 1;
   localparam int ST_RUN_BIT      = 2;
   localparam int ST_SEL_LSB      = 8;
   localparam int WDT_EN_BIT      = 0;

   // Values after reset and codes
   localparam logic [2:0] SEL_RST     = 3'h0;
   localparam logic [2:0] SEL_SUB     = 3'h7;
   localparam logic       HS_EN_RST   = 1'b1;
   localparam logic [1:0] HS_FREQ_RST = 2'h0;
   localparam logic       WDT_EN_RST  = 1'b1;

   typedef enum logic [3:0] {
      MODE_FAST,
      MODE_SLOW,
      MODE_TO_SLOW,
      MODE_TO_FAST,
      MODE_SLEEP,
      MODE_IDLE_SLOW,
      MODE_IDLE_BOTH,
      MODE_IDLE_FAST,
      MODE_WAKE
   } pmsw_mode_e;
endpackage

// [pmsw_osc_if.sv]
`timescale 1ns/1ns
interface pmsw_osc_if;
   logic on;
   logic restart;
   logic stable;
   modport ctl (output on, output restart, input stable);
   modport osc (input on, input restart, output stable);
endinterface

// [pmsw_osc_settle.sv]
`timescale 1ns/1ns
module pmsw_osc_settle
   import pmsw_pkg::*;
#(
   parameter int CYCLES = HS_SETTLE_CYC
)(
   input  wire logic clk_i,
   input  wire logic rst_i,
   pmsw_osc_if.osc   osc
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic          stable;
   logic          next_stable;

   // Stop or restart drops the flag first, then it counts up again
   always_comb begin
      next_cnt    = cnt;
      next_stable = stable;
      if (!osc.on || osc.restart) begin
         next_cnt    = '0;
         next_stable = 1'b0;
      end else if (!stable) begin
         if (cnt == CW'(CYCLES - 1))
            next_stable = 1'b1;
         else
            next_cnt = cnt + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt    <= '0;
         stable <= 1'b0;
      end else begin
         cnt    <= next_cnt;
         stable <= next_stable;
      end
   end

   assign osc.stable = stable;
endmodule

// [pmsw_top.sv]
// Notes on behaviour
// - Halt picks sleep or an idle mode from the fast and slow keep bits.
// - Select code 111 in fast mode moves the system clock to the sub clock.
// - Switch to slow mode completes only after the low-speed oscillator is stable.
// - Codes 000 to 110 in slow mode return to the divided fast clock.
// - Return to fast waits for the fast oscillator; software may poll its stable flag.
// - Halt with both keep bits 0 enters sleep; all but watchdog stops.
// - Halt with fast keep 0, slow keep 1 enters slow-only idle.
// - Halt with both keep bits 1 enters idle with both clocks running.
// - Halt with fast keep 1, slow keep 0 enters fast-only idle, sub clock off.
// - Low-power entry keeps memory, registers and port states unchanged.
// - Low-power entry sets the power-down flag and clears the timeout flag.
// - Low-power entry clears the watchdog counter; it runs only if enabled.
// - Wake on enabled port falling edge, system interrupt or watchdog overflow.
// - Power-down flag clears only on power-up or clear-watchdog instruction.
// - Watchdog overflow in low power sets timeout, wakes, resets only PC and SP.
// - Per-pin wake enable; pin wake resumes after the halt.
// - Disabled interrupt or full stack: resume after halt, request stays pending.
// - Enabled interrupt with free stack takes the normal interrupt response on wake.
// - An interrupt already requested at halt cannot wake the device.
// - Execution resumes only after the original system oscillator is stable again.
// - Codes 000 to 110 divide the fast clock by 1 to 64; 111 is sub clock.
// - Enabling or retuning the fast oscillator clears its stable flag until settled.
// - In sleep the low-speed oscillator runs only while the watchdog is enabled.
`timescale 1ns/1ns
module pmsw_top
   import pmsw_pkg::*;
#(
   parameter int PORT_W = 8,
   parameter int IRQ_W  = 4,
   parameter int HS_CYC = HS_SETTLE_CYC,
   parameter int LS_CYC = LS_SETTLE_CYC
)(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic [3:0]        wb_sel_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              halt_exec_i,
   input  wire logic              clr_wdt_i,
   input  wire logic              wdt_overflow_i,
   input  wire logic [PORT_W-1:0] port_a_i,
   input  wire logic [IRQ_W-1:0]  irq_req_i,
   input  wire logic [IRQ_W-1:0]  irq_enable_i,
   input  wire logic              stack_full_i,
   output logic      [2:0]        sys_clk_code_o,
   output logic                   fast_clk_on_o,
   output logic                   sub_clk_on_o,
   output logic                   low_speed_rc_osc_on_o,
   output logic                   cpu_run_o,
   output logic                   io_hold_o,
   output logic                   wdt_clear_o,
   output logic                   wdt_count_en_o,
   output logic                   resume_next_o,
   output logic                   irq_response_o,
   output logic                   pc_sp_reset_o,
   output logic                   power_down_flag_o,
   output logic                   watchdog_timeout_flag_o
);
   function automatic logic is_low_power(pmsw_mode_e m);
      return (m == MODE_SLEEP) || (m == MODE_IDLE_SLOW) || (m == MODE_IDLE_BOTH) || (m == MODE_IDLE_FAST);
   endfunction

   function automatic logic is_running(pmsw_mode_e m);
      return !is_low_power(m) && (m != MODE_WAKE);
   endfunction

   // Software registers
   logic [2:0]        system_clock_select;
   logic [2:0]        next_system_clock_select;
   logic              fast_osc_halt_keep;
   logic              next_fast_osc_halt_keep;
   logic              slow_osc_halt_keep;
   logic              next_slow_osc_halt_keep;
   logic              hs_osc_enable;
   logic              next_hs_osc_enable;
   logic [1:0]        hs_freq;
   logic [1:0]        next_hs_freq;
   logic [PORT_W-1:0] port_wake_enable;
   logic [PORT_W-1:0] next_port_wake_enable;
   logic              wdt_enable;
   logic              next_wdt_enable;
   logic              hs_restart;
   logic              next_hs_restart;
   logic [31:0]       next_dat;
   logic              next_ack;
   logic              hs_osc_stable_flag;
   logic              ls_stable;

   pmsw_osc_if hs_if ();
   pmsw_osc_if ls_if ();

   pmsw_osc_settle #(.CYCLES(HS_CYC)) u_hs_settle (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .osc   (hs_if)
   );

   pmsw_osc_settle #(.CYCLES(LS_CYC)) u_ls_settle (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .osc   (ls_if)
   );

   assign hs_if.on           = fast_clk_on_o;
   assign hs_if.restart      = hs_restart;
   assign ls_if.on           = low_speed_rc_osc_on_o;
   assign ls_if.restart      = 1'b0;
   assign hs_osc_stable_flag = hs_if.stable;
   assign ls_stable          = ls_if.stable;

   // Wishbone slave; ack one cycle after the strobe, dropped the next
   logic bus_go;
   logic bus_wr;
   assign bus_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_go && wb_we_i && wb_sel_i[0];

   always_comb begin
      next_system_clock_select = system_clock_select;
      next_fast_osc_halt_keep  = fast_osc_halt_keep;
      next_slow_osc_halt_keep  = slow_osc_halt_keep;
      next_hs_osc_enable       = hs_osc_enable;
      next_hs_freq             = hs_freq;
      next_port_wake_enable    = port_wake_enable;
      next_wdt_enable          = wdt_enable;
      next_hs_restart          = 1'b0;
      next_ack                 = bus_go;
      next_dat                 = 32'h0000_0000;
      if (bus_wr) begin
         case (wb_adr_i)
            OFS_CLK_CTRL: begin
               next_system_clock_select = wb_dat_i[SEL_LSB +: 3];
               next_fast_osc_halt_keep  = wb_dat_i[FAST_KEEP_BIT];
               next_slow_osc_halt_keep  = wb_dat_i[SLOW_KEEP_BIT];
            end
            OFS_HS_CTRL: begin
               next_hs_osc_enable = wb_dat_i[HS_EN_BIT];
               next_hs_freq       = wb_dat_i[HS_FREQ_LSB +: 2];
               // Enable rise or retune restarts the settle count
               next_hs_restart    = (wb_dat_i[HS_EN_BIT] && !hs_osc_enable) ||
                                    (wb_dat_i[HS_FREQ_LSB +: 2] != hs_freq);
            end
            OFS_WAKE_EN:  next_port_wake_enable = wb_dat_i[PORT_W-1:0];
            OFS_WDT_CTRL: next_wdt_enable       = wb_dat_i[WDT_EN_BIT];
            default: ;
         endcase
      end
      if (bus_go && !wb_we_i) begin
         case (wb_adr_i)
            OFS_CLK_CTRL: begin
               next_dat[SEL_LSB +: 3]   = system_clock_select;
               next_dat[FAST_KEEP_BIT]  = fast_osc_halt_keep;
               next_dat[SLOW_KEEP_BIT]  = slow_osc_halt_keep;
            end
            OFS_HS_CTRL: begin
               next_dat[HS_EN_BIT]        = hs_osc_enable;
               next_dat[HS_STABLE_BIT]    = hs_osc_stable_flag;
               next_dat[HS_FREQ_LSB +: 2] = hs_freq;
            end
            OFS_STATUS: begin
               next_dat[ST_PDF_BIT]      = power_down_flag_o;
               next_dat[ST_TO_BIT]       = watchdog_timeout_flag_o;
               next_dat[ST_RUN_BIT]      = cpu_run_o;
               next_dat[ST_SEL_LSB +: 3] = sys_clk_code_o;
            end
            OFS_WAKE_EN:  next_dat[PORT_W-1:0] = port_wake_enable;
            OFS_WDT_CTRL: next_dat[WDT_EN_BIT] = wdt_enable;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         system_clock_select <= SEL_RST;
         fast_osc_halt_keep  <= 1'b0;
         slow_osc_halt_keep  <= 1'b0;
         hs_osc_enable       <= HS_EN_RST;
         hs_freq             <= HS_FREQ_RST;
         port_wake_enable    <= '0;
         wdt_enable          <= WDT_EN_RST;
         hs_restart          <= 1'b0;
         wb_ack_o            <= 1'b0;
         wb_dat_o            <= 32'h0000_0000;
      end else begin
         system_clock_select <= next_system_clock_select;
         fast_osc_halt_keep  <= next_fast_osc_halt_keep;
         slow_osc_halt_keep  <= next_slow_osc_halt_keep;
         hs_osc_enable       <= next_hs_osc_enable;
         hs_freq             <= next_hs_freq;
         port_wake_enable    <= next_port_wake_enable;
         wdt_enable          <= next_wdt_enable;
         hs_restart          <= next_hs_restart;
         wb_ack_o            <= next_ack;
         wb_dat_o            <= next_dat;
      end
   end

   // Port pins are asynchronous: two flops before the edge detector
   logic [PORT_W-1:0] pa_meta;
   logic [PORT_W-1:0] pa_sync;
   logic [PORT_W-1:0] pa_prev;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pa_meta <= '1;
         pa_sync <= '1;
         pa_prev <= '1;
      end else begin
         pa_meta <= port_a_i;
         pa_sync <= pa_meta;
         pa_prev <= pa_sync;
      end
   end

   // Mode machine
   pmsw_mode_e       mode;
   pmsw_mode_e       next_mode;
   logic [IRQ_W-1:0] irq_blocked;
   logic [IRQ_W-1:0] next_irq_blocked;
   logic [2:0]       next_code;
   logic             next_pdf;
   logic             next_to;
   logic             next_fast_on;
   logic             next_sub_on;
   logic             next_low_speed_rc_osc_on;
   logic             next_hold;
   logic             next_wdt_clear;
   logic             next_resume;
   logic             next_irq_resp;
   logic             next_pc_sp;
   logic             wake_cause_wdt;
   logic             next_wake_cause_wdt;
   logic             wake_cause_irq;
   logic             next_wake_cause_irq;
   logic             halt_ok;
   logic             pin_wake;
   logic             irq_wake;
   logic             irq_serve;
   logic             orig_stable;

   assign halt_ok     = halt_exec_i && is_running(mode);
   assign pin_wake    = |(pa_prev & ~pa_sync & port_wake_enable);
   assign irq_wake    = |(irq_req_i & ~irq_blocked);
   assign irq_serve   = |(irq_req_i & ~irq_blocked & irq_enable_i) && !stack_full_i;
   assign orig_stable = (sys_clk_code_o == SEL_SUB) ? ls_stable : hs_osc_stable_flag;

   always_comb begin
      next_mode           = mode;
      next_code           = sys_clk_code_o;
      next_irq_blocked    = irq_blocked;
      next_pdf            = power_down_flag_o;
      next_to             = watchdog_timeout_flag_o;
      next_wdt_clear      = 1'b0;
      next_resume         = 1'b0;
      next_irq_resp       = 1'b0;
      next_pc_sp          = 1'b0;
      next_wake_cause_wdt = wake_cause_wdt;
      next_wake_cause_irq = wake_cause_irq;
      if (clr_wdt_i)
         next_pdf = 1'b0;
      if (halt_ok) begin
         // Keep bits as they stand in the halt cycle choose the mode
         case ({fast_osc_halt_keep, slow_osc_halt_keep})
            2'b00:   next_mode = MODE_SLEEP;
            2'b01:   next_mode = MODE_IDLE_SLOW;
            2'b11:   next_mode = MODE_IDLE_BOTH;
            default: next_mode = MODE_IDLE_FAST;
         endcase
         next_irq_blocked = irq_req_i;
         next_pdf         = 1'b1;
         next_to          = 1'b0;
         next_wdt_clear   = 1'b1;
      end else begin
         case (mode)
            MODE_FAST: begin
               if (system_clock_select == SEL_SUB)
                  next_mode = MODE_TO_SLOW;
               else
                  next_code = system_clock_select;
            end
            MODE_TO_SLOW: begin
               if (system_clock_select != SEL_SUB)
                  next_mode = MODE_FAST;
               else if (ls_stable) begin
                  next_mode = MODE_SLOW;
                  next_code = SEL_SUB;
               end
            end
            MODE_SLOW, MODE_TO_FAST: begin
               if (system_clock_select == SEL_SUB)
                  next_mode = MODE_SLOW;
               else if (hs_osc_stable_flag) begin
                  next_mode = MODE_FAST;
                  next_code = system_clock_select;
               end else
                  next_mode = MODE_TO_FAST;
            end
            MODE_SLEEP, MODE_IDLE_SLOW, MODE_IDLE_BOTH, MODE_IDLE_FAST: begin
               if (wdt_overflow_i || irq_wake || pin_wake) begin
                  next_mode           = MODE_WAKE;
                  next_wake_cause_wdt = wdt_overflow_i;
                  next_wake_cause_irq = !wdt_overflow_i && irq_wake && irq_serve;
               end
            end
            MODE_WAKE: begin
               if (orig_stable) begin
                  next_mode     = (sys_clk_code_o == SEL_SUB) ? MODE_SLOW : MODE_FAST;
                  next_pc_sp    = wake_cause_wdt;
                  next_irq_resp = !wake_cause_wdt && wake_cause_irq;
                  // Pending request is left for the interrupt controller
                  next_resume   = !wake_cause_wdt && !wake_cause_irq;
               end
            end
            default: next_mode = MODE_FAST;
         endcase
      end
      // Timeout set wins over the halt clear
      if (wdt_overflow_i)
         next_to = 1'b1;
   end

   // Clock gating follows the next mode so outputs stay registered
   always_comb begin
      case (next_mode)
         MODE_SLEEP: begin
            next_fast_on = 1'b0;
            next_sub_on  = 1'b0;
            next_low_speed_rc_osc_on = next_wdt_enable;
         end
         MODE_IDLE_SLOW: begin
            next_fast_on = 1'b0;
            next_sub_on  = 1'b1;
            next_low_speed_rc_osc_on = 1'b1;
         end
         MODE_IDLE_FAST: begin
            next_fast_on = 1'b1;
            next_sub_on  = 1'b0;
            next_low_speed_rc_osc_on = 1'b1;
         end
         MODE_SLOW: begin
            next_fast_on = next_hs_osc_enable;
            next_sub_on  = 1'b1;
            next_low_speed_rc_osc_on = 1'b1;
         end
         MODE_WAKE: begin
            next_fast_on = (sys_clk_code_o != SEL_SUB) || next_hs_osc_enable;
            next_sub_on  = 1'b1;
            next_low_speed_rc_osc_on = 1'b1;
         end
         default: begin
            next_fast_on = 1'b1;
            next_sub_on  = 1'b1;
            next_low_speed_rc_osc_on = 1'b1;
         end
      endcase
      next_hold = is_low_power(next_mode);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode                    <= MODE_FAST;
         sys_clk_code_o          <= SEL_RST;
         irq_blocked             <= '0;
         power_down_flag_o       <= 1'b0;
         watchdog_timeout_flag_o <= 1'b0;
         fast_clk_on_o           <= 1'b1;
         sub_clk_on_o            <= 1'b1;
         low_speed_rc_osc_on_o               <= 1'b1;
         cpu_run_o               <= 1'b1;
         io_hold_o               <= 1'b0;
         wdt_clear_o             <= 1'b0;
         wdt_count_en_o          <= WDT_EN_RST;
         resume_next_o           <= 1'b0;
         irq_response_o          <= 1'b0;
         pc_sp_reset_o           <= 1'b0;
         wake_cause_wdt          <= 1'b0;
         wake_cause_irq          <= 1'b0;
      end else begin
         mode                    <= next_mode;
         sys_clk_code_o          <= next_code;
         irq_blocked             <= next_irq_blocked;
         power_down_flag_o       <= next_pdf;
         watchdog_timeout_flag_o <= next_to;
         fast_clk_on_o           <= next_fast_on;
         sub_clk_on_o            <= next_sub_on;
         low_speed_rc_osc_on_o               <= next_low_speed_rc_osc_on;
         cpu_run_o               <= is_running(next_mode);
         io_hold_o               <= next_hold;
         wdt_clear_o             <= next_wdt_clear;
         wdt_count_en_o          <= next_wdt_enable;
         resume_next_o           <= next_resume;
         irq_response_o          <= next_irq_resp;
         pc_sp_reset_o           <= next_pc_sp;
         wake_cause_wdt          <= next_wake_cause_wdt;
         wake_cause_irq          <= next_wake_cause_irq;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_halt_taken;
      halt_ok && !wdt_overflow_i;
   endsequence
   sequence s_entry_marks;
      power_down_flag_o && !watchdog_timeout_flag_o && wdt_clear_o && io_hold_o && !cpu_run_o;
   endsequence

   halt_sleep_a:  assert property (halt_ok && !fast_osc_halt_keep && !slow_osc_halt_keep |=> mode == MODE_SLEEP)
      else $error("halt with keep 00 did not enter sleep");
   halt_idle_slow_a: assert property (halt_ok && !fast_osc_halt_keep && slow_osc_halt_keep |=> mode == MODE_IDLE_SLOW && !fast_clk_on_o)
      else $error("halt with keep 01 did not enter slow-only idle");
   halt_idle_both_a: assert property (halt_ok && fast_osc_halt_keep && slow_osc_halt_keep |=> fast_clk_on_o && sub_clk_on_o)
      else $error("both-clock idle lost a clock");
   halt_idle_fast_a: assert property (halt_ok && fast_osc_halt_keep && !slow_osc_halt_keep |=> fast_clk_on_o && !sub_clk_on_o)
      else $error("fast-only idle clock gating wrong");
   entry_flags_a: assert property (s_halt_taken |=> s_entry_marks)
      else $error("low-power entry flags or pulses wrong");
   pdf_clear_a:   assert property ($fell(power_down_flag_o) |-> $past(clr_wdt_i))
      else $error("power-down flag cleared without clear-watchdog");
   slow_wait_a:   assert property (mode == MODE_TO_SLOW && !ls_stable && !halt_exec_i |=> mode != MODE_SLOW)
      else $error("slow mode entered before low oscillator stable");
   slow_code_a:   assert property (mode == MODE_SLOW |-> sys_clk_code_o == SEL_SUB)
      else $error("slow mode not on sub clock");
   to_wake_a:     assert property (is_low_power(mode) && wdt_overflow_i |=> watchdog_timeout_flag_o && mode == MODE_WAKE)
      else $error("watchdog overflow did not wake with timeout set");
   wake_hold_a:   assert property (mode == MODE_WAKE && !orig_stable |=> !cpu_run_o ##0 !resume_next_o[*1])
      else $error("resumed before oscillator stable");
   low_speed_rc_osc_sleep_a:  assert property (mode == MODE_SLEEP |-> low_speed_rc_osc_on_o == wdt_enable)
      else $error("low oscillator state in sleep wrong");
   pin_wake_a:    assert property (is_low_power(mode) && pin_wake |=> mode == MODE_WAKE)
      else $error("enabled pin edge did not wake");
endmodule

// [pmsw_core_model.sv]
`timescale 1ns/1ns
module pmsw_core_model (
   input  wire logic req_i,
   input  wire logic cpu_run_i,
   output logic      halt_exec_o
);
   // A halted core cannot issue a further halt
   assign halt_exec_o = req_i & cpu_run_i;
endmodule

// [power_mode_switch_wakeup_tb_top.sv]
`timescale 1ns/1ns
module power_mode_switch_wakeup_tb_top;
   import pmsw_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, hreq = 0, clr = 0, ovf = 0, sfull = 0;
   logic [7:0]  adr = 0, port = 8'hFF;
   logic [3:0]  irq = 0, ien = 0;
   logic [31:0] dat = 0, rd, seed = 32'h04FA;
   logic [31:0] dat_o;
   logic [2:0]  code;
   logic        ack, halt, run, hold, fon, son, power_down_flag, tof, res, irs, pcs, wcl, lon, wen;
   int          err_total = 0, num_checks = 0, n_res = 0, n_irs = 0, n_pcs = 0, n_wcl = 0;
   int          k, p, m, r0, i0, p0, w0;
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      n_res += (res === 1'b1);
      n_irs += (irs === 1'b1);
      n_pcs += (pcs === 1'b1);
      n_wcl += (wcl === 1'b1);
   end
   pmsw_core_model u_pmsw_core_model (.req_i(hreq), .cpu_run_i(run), .halt_exec_o(halt));
   // Short settle counts keep the run brief; low settle outlasts a bus write so slow entry must wait
   pmsw_top #(.HS_CYC(4), .LS_CYC(12)) u_pmsw_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .halt_exec_i(halt), .clr_wdt_i(clr), .wdt_overflow_i(ovf), .port_a_i(port), .irq_req_i(irq),
      .irq_enable_i(ien), .stack_full_i(sfull), .sys_clk_code_o(code), .fast_clk_on_o(fon), .sub_clk_on_o(son),
      .low_speed_rc_osc_on_o(lon), .cpu_run_o(run), .io_hold_o(hold), .wdt_clear_o(wcl), .wdt_count_en_o(wen),
      .resume_next_o(res), .irq_response_o(irs), .pc_sp_reset_o(pcs), .power_down_flag_o(power_down_flag),
      .watchdog_timeout_flag_o(tof));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic stop_test();
      if (err_total == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic do_halt();
      @(posedge clk_i) hreq <= 1;
      @(posedge clk_i) hreq <= 0;
   endtask
   // A wake that never completes counts as a mismatch
   task automatic wait_run();
      int j;
      for (j = 0; j < 100 && run !== 1'b1; j++) @(posedge clk_i);
      if (j == 100) err_total++;
      tick(2);
   endtask
   // Request held until the edge that samples ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   initial begin
      #(100 * 5000);
      err_total++;
      stop_test();
   end
   initial begin
      tick(20);
      rst_i <= 0;
      wb(0, OFS_STATUS, 0);
      chk("status", 32'h4, rd & 32'h7);
      wb(1, OFS_CLK_CTRL, {SEL_SUB, 5'h00});
      tick(20);
      chk("code", 7, code);
      k = xs() % 7;
      wb(1, OFS_CLK_CTRL, k << 5);
      tick(20);
      chk("code", k, code);
      p = xs() % 8;
      wb(1, OFS_WAKE_EN, 1 << p);
      for (m = 0; m < 4; m++) begin
         // Watchdog, pin, then irq enabled and disabled per mode so every path is reached
         wb(1, OFS_CLK_CTRL, (k << 5) | m);
         {r0, i0, p0, w0} = {n_res, n_irs, n_pcs, n_wcl};
         @(posedge clk_i) hreq <= 1;
         @(posedge clk_i) hreq <= 0;
         tick(2);
         chk("fast_on", m[1], fon);
         chk("sub_on", m[0], son);
         chk("run_hold", 2'b01, {run, hold});
         chk("flags", 2'b10, {power_down_flag, tof});
         chk("wdt_clr", w0 + 1, n_wcl);
         @(posedge clk_i) begin
            if (m == 0) ovf <= 1;
            if (m == 1) port[p] <= 0;
            if (m >= 2) irq <= 4'h1;
            ien <= (m == 2) ? 4'h1 : 4'h0;
         end
         @(posedge clk_i) ovf <= 0;
         wait_run();
         {irq, port} <= {4'h0, 8'hFF};
         chk("pc_sp", m == 0, n_pcs - p0);
         chk("irq_resp", m == 2, n_irs - i0);
         chk("resume", m[0], n_res - r0);
         chk("flags", {1'b1, m == 0}, {power_down_flag, tof});
      end
      @(posedge clk_i) clr <= 1;
      @(posedge clk_i) clr <= 0;
      tick(2);
      chk("pdf", 0, power_down_flag);
      // Watchdog off: sleep stops the low oscillator; irq raised before halt must not wake
      wb(1, OFS_WDT_CTRL, 0);
      wb(1, OFS_CLK_CTRL, k << 5);
      {irq, ien} <= {4'h2, 4'h2};
      chk("wdt_en", 0, wen);
      {r0, i0} = {n_res, n_irs};
      do_halt();
      tick(8);
      chk("low_speed_rc_osc_on", 0, lon);
      chk("run_hold", 2'b01, {run, hold});
      @(posedge clk_i) port[p] <= 0;
      wait_run();
      {irq, ien, port} <= {4'h0, 4'h0, 8'hFF};
      chk("resume", 1, n_res - r0);
      chk("irq_resp", 0, n_irs - i0);
      // Fast oscillator off in slow mode, so the return must wait for it
      wb(1, OFS_CLK_CTRL, {SEL_SUB, 5'h00});
      wb(1, OFS_HS_CTRL, 0);
      tick(20);
      wb(0, OFS_HS_CTRL, 0);
      chk("hs_ctrl", 0, rd);
      wb(1, OFS_HS_CTRL, 1);
      wb(1, OFS_CLK_CTRL, k << 5);
      tick(1);
      chk("code", 7, code);
      tick(10);
      wb(0, OFS_HS_CTRL, 0);
      chk("hs_ctrl", 3, rd);
      chk("code", k, code);
      // Enabled interrupt with full stack resumes without the interrupt response
      wb(1, OFS_CLK_CTRL, (k << 5) | 3);
      {ien, sfull} <= {4'h1, 1'b1};
      {r0, i0} = {n_res, n_irs};
      do_halt();
      @(posedge clk_i) irq <= 4'h1;
      wait_run();
      chk("resume", 1, n_res - r0);
      chk("irq_resp", 0, n_irs - i0);
      stop_test();
   end
endmodule
